// file: shared/rnwmf_pkg.sv
// shared constants for the reading noise-window / median filter stage
// assumes one 25 MHz clock and a word-addressed avalon-mm register port
package rnwmf_pkg;

    // ------------------------------------------------------------
    // register map (word index on avs_address)
    // ------------------------------------------------------------
    localparam logic [3:0] RNWMF_REG_CTRL = 4'h0;
    localparam logic [3:0] RNWMF_REG_AVG_DEPTH = 4'h1;
    localparam logic [3:0] RNWMF_REG_NOISE_TOL = 4'h2;
    localparam logic [3:0] RNWMF_REG_MED_RANK = 4'h3;
    localparam logic [3:0] RNWMF_REG_CH2_BASE = 4'h4;
    localparam logic [3:0] RNWMF_REG_STATUS = 4'h8;
    localparam logic [3:0] RNWMF_REG_RESULT = 4'h9;

    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int RNWMF_CTRL_AVG_EN = 0;
    localparam int RNWMF_CTRL_SLIDE = 1;
    localparam int RNWMF_CTRL_NOISE_EN = 2;
    localparam int RNWMF_CTRL_MED_EN = 3;
    localparam int RNWMF_CTRL_W = 4;

    // status field positions
    localparam int RNWMF_STAT_FILL_LSB = 0;
    localparam int RNWMF_STAT_IDLE = 8;
    localparam int RNWMF_STAT_REF_VLD = 9;
    localparam int RNWMF_STAT_FLUSH_LSB = 16;

    // ------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------
    localparam logic [3:0] RNWMF_CTRL_RST = 4'h1;
    localparam logic [6:0] RNWMF_DEPTH_RST = 7'h0A;
    localparam logic [6:0] RNWMF_DEPTH_MIN = 7'h01;
    localparam logic [6:0] RNWMF_DEPTH_MAX = 7'h64;
    localparam logic [6:0] RNWMF_TOL_RST = 7'h05;
    localparam logic [6:0] RNWMF_TOL_MIN = 7'h00;
    localparam logic [6:0] RNWMF_TOL_MAX = 7'h64;
    localparam logic [6:0] RNWMF_PCT_SCALE = 7'h64;
    localparam logic [2:0] RNWMF_RANK_RST = 3'h1;
    localparam logic [2:0] RNWMF_RANK_MAX = 3'h5;
    localparam int RNWMF_MED_MAX_N = 11;

    // sequencer states, one-hot
    typedef enum logic [6:0] {
        RNWMF_S_IDLE  = 7'b0000001,
        RNWMF_S_MED   = 7'b0000010,
        RNWMF_S_NOISE = 7'b0000100,
        RNWMF_S_RD    = 7'b0001000,
        RNWMF_S_CHK   = 7'b0010000,
        RNWMF_S_DIV   = 7'b0100000,
        RNWMF_S_OUT   = 7'b1000000
    } rnwmf_state_e;

endpackage : rnwmf_pkg

// file: core/rnwmf_sample_mem.sv
// averaging sample store: one write port, one read port
// read data come out of a register one clock after the read request
`timescale 1ns/10ps
module rnwmf_sample_mem #(
    parameter int DW = 24,
    parameter int DEPTH = 100,
    parameter int AW = 7
) (
    input wire logic sys_clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);

    logic [DW-1:0] mem [0:DEPTH-1];

    // write port; contents need no reset, the fill count guards reads
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read port
    always_ff @(posedge sys_clk) begin
        if (re) begin
            rdata <= mem[raddr];
        end
    end

endmodule : rnwmf_sample_mem

// file: core/rnwmf_filter.sv
// reading conditioning stage: median filter then averaging filter with noise window
// assumes readings arrive on sys_clk with a valid/ready handshake, settings over avalon-mm
//
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
module rnwmf_filter import rnwmf_pkg::*; #(
    parameter int DW = 24,
    parameter int DEPTH = 100
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [DW-1:0] in_data,
    output logic out_valid,
    output logic [DW-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);
    localparam int SW = DW + 8;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [6:0] clamp7(input logic [31:0] v, input logic [6:0] lo,
                                          input logic [6:0] hi);
        if (v > {25'h0, hi}) begin
            clamp7 = hi;
        end else if (v < {25'h0, lo}) begin
            clamp7 = lo;
        end else begin
            clamp7 = v[6:0];
        end
    endfunction : clamp7

    function automatic logic [SW-1:0] abs_sw(input logic signed [SW-1:0] v);
        abs_sw = v[SW-1] ? SW'(-v) : SW'(v);
    endfunction : abs_sw

    // ------------------------------------------------------------
    // settings and bus slave
    // ------------------------------------------------------------
    logic [RNWMF_CTRL_W-1:0] ctrl_q;
    logic [6:0] depth_q;
    logic [6:0] tol_q;
    logic [2:0] rank_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic wr_fire;
    logic set_sel;
    logic [1:0] set_idx;
    logic restart_q;
    logic restart_take;
    logic [15:0] flush_cnt_q;
    rnwmf_state_e state_q;

    // one wait cycle for every access keeps read data registered
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign avs_readdata = rdata_q;
    assign wr_fire = avs_write & ack_q;
    // both channel aliases land on one set of settings
    assign set_sel = (avs_address < RNWMF_REG_STATUS);
    assign set_idx = avs_address[1:0];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    // settings writes clamp to the legal range rather than refusing
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q <= RNWMF_CTRL_RST;
            depth_q <= RNWMF_DEPTH_RST;
            tol_q <= RNWMF_TOL_RST;
            rank_q <= RNWMF_RANK_RST;
        end else if (wr_fire && set_sel) begin
            unique case (set_idx)
                2'h0: ctrl_q <= avs_writedata[RNWMF_CTRL_W-1:0];
                2'h1: depth_q <= clamp7(avs_writedata, RNWMF_DEPTH_MIN, RNWMF_DEPTH_MAX);
                2'h2: tol_q <= clamp7(avs_writedata, RNWMF_TOL_MIN, RNWMF_TOL_MAX);
                2'h3: rank_q <= (avs_writedata > 32'h5) ? RNWMF_RANK_MAX
                                                        : avs_writedata[2:0];
            endcase
        end
    end

    // a settings write restarts both filters; a new write wins over the take
    assign restart_take = restart_q && (state_q == RNWMF_S_IDLE);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            restart_q <= 1'b0;
        end else begin
            restart_q <= (wr_fire && set_sel) | (restart_q & ~restart_take);
        end
    end

    // ------------------------------------------------------------
    // median window
    // ------------------------------------------------------------
    logic signed [DW-1:0] win_q [0:RNWMF_MED_MAX_N-1];
    logic [3:0] fill_q;
    logic [3:0] med_n;
    logic signed [DW-1:0] med_val;
    logic signed [DW-1:0] raw_q;
    logic take_in;

    assign med_n = {rank_q, 1'b1};
    assign in_ready = (state_q == RNWMF_S_IDLE) & ~restart_q;
    assign take_in = in_valid & in_ready;

    // newest reading enters at slot 0, oldest falls off the end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fill_q <= 4'h0;
            raw_q <= '0;
        end else if (restart_take) begin
            fill_q <= 4'h0;
        end else if (take_in) begin
            raw_q <= in_data;
            if (fill_q < med_n) begin
                fill_q <= fill_q + 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (take_in) begin
            win_q[0] <= in_data;
            for (int k = 1; k < RNWMF_MED_MAX_N; k++) begin
                win_q[k] <= win_q[k-1];
            end
        end
    end

    // rank by counting smaller entries; equal values break ties by slot
    always_comb begin
        logic [3:0] lt;
        lt = 4'h0;
        med_val = win_q[0];
        for (int i = 0; i < RNWMF_MED_MAX_N; i++) begin
            lt = 4'h0;
            for (int j = 0; j < RNWMF_MED_MAX_N; j++) begin
                if ((4'(j) < med_n) && ((win_q[j] < win_q[i]) ||
                    ((win_q[j] == win_q[i]) && (j < i)))) begin
                    lt = lt + 4'h1;
                end
            end
            if ((4'(i) < med_n) && (lt == {1'b0, rank_q})) begin
                med_val = win_q[i];
            end
        end
    end

    // ------------------------------------------------------------
    // averaging datapath
    // ------------------------------------------------------------
    logic signed [DW-1:0] x_q;
    logic signed [DW-1:0] ref_q;
    logic signed [DW-1:0] res_q;
    logic ref_vld_q;
    logic signed [SW-1:0] sum_q;
    logic [6:0] cnt_q;
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] wptr_inc;
    logic [SW-1:0] dvd_q;
    logic [6:0] rem_q;
    logic [5:0] div_cnt_q;
    logic div_neg_q;
    logic [7:0] trial;
    logic [DW-1:0] quo;
    logic full;
    logic outside;
    logic flush;
    logic [SW-1:0] dev_abs;
    logic [SW-1:0] lhs;
    logic [SW-1:0] rhs;
    logic mem_we;
    logic mem_re;
    logic [AW-1:0] mem_waddr;
    logic [DW-1:0] mem_rdata;

    assign full = (cnt_q == depth_q);
    assign wptr_inc = ({1'b0, wptr_q} + 8'h1 >= {1'b0, depth_q}) ? '0 : AW'(wptr_q + 1'b1);
    // window test against the last averaging result, in percent
    assign dev_abs = abs_sw(SW'(x_q) - SW'(ref_q));
    assign lhs = SW'(dev_abs * RNWMF_PCT_SCALE);
    assign rhs = SW'(abs_sw(SW'(ref_q)) * tol_q);
    assign outside = ref_vld_q && (lhs > rhs);
    assign flush = ctrl_q[RNWMF_CTRL_NOISE_EN] && outside;
    assign trial = {rem_q, dvd_q[SW-1]};
    // the last quotient bit is folded in here: the shifter only takes it on the same edge
    assign quo = {dvd_q[DW-2:0], (trial >= {1'b0, depth_q})};

    // memory strobes follow the sequencer
    assign mem_we = ((state_q == RNWMF_S_NOISE) && !(!flush && ctrl_q[RNWMF_CTRL_SLIDE] && full))
                    || (state_q == RNWMF_S_RD);
    assign mem_waddr = ((state_q == RNWMF_S_NOISE) && flush) ? '0 : wptr_q;
    assign mem_re = (state_q == RNWMF_S_NOISE) && !flush && ctrl_q[RNWMF_CTRL_SLIDE] && full;

    rnwmf_sample_mem #(.DW(DW), .DEPTH(DEPTH), .AW(AW)) u_mem (
        .sys_clk(sys_clk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(x_q),
        .re(mem_re),
        .raddr(wptr_q),
        .rdata(mem_rdata)
    );

    // sequencer: one reading in flight at a time, so no buffering is needed
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= RNWMF_S_IDLE;
        end else begin
            unique case (state_q)
                RNWMF_S_IDLE: if (take_in) state_q <= RNWMF_S_MED;
                RNWMF_S_MED: begin
                    if (ctrl_q[RNWMF_CTRL_MED_EN] && fill_q < med_n) begin
                        state_q <= RNWMF_S_IDLE;
                    end else if (ctrl_q[RNWMF_CTRL_AVG_EN]) begin
                        state_q <= RNWMF_S_NOISE;
                    end else begin
                        state_q <= RNWMF_S_OUT;
                    end
                end
                RNWMF_S_NOISE: state_q <= mem_re ? RNWMF_S_RD : RNWMF_S_CHK;
                RNWMF_S_RD: state_q <= RNWMF_S_CHK;
                RNWMF_S_CHK: state_q <= full ? RNWMF_S_DIV : RNWMF_S_IDLE;
                RNWMF_S_DIV: if (div_cnt_q == 6'(SW - 1)) state_q <= RNWMF_S_OUT;
                RNWMF_S_OUT: state_q <= RNWMF_S_IDLE;
                default: state_q <= RNWMF_S_IDLE;
            endcase
        end
    end

    // median pick or bypass
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            x_q <= '0;
        end else if (state_q == RNWMF_S_MED) begin
            x_q <= ctrl_q[RNWMF_CTRL_MED_EN] ? med_val : raw_q;
        end
    end

    // buffer bookkeeping: fill count, write pointer and running sum
    always_ff @(posedge sys_clk) begin
        if (rst || restart_take) begin
            cnt_q <= 7'h0;
            wptr_q <= '0;
            sum_q <= '0;
        end else begin
            unique case (state_q)
                RNWMF_S_NOISE: begin
                    if (flush) begin
                        cnt_q <= 7'h1;
                        wptr_q <= (depth_q == RNWMF_DEPTH_MIN) ? '0 : AW'(1);
                        sum_q <= SW'(x_q);
                    end else if (!mem_re) begin
                        cnt_q <= cnt_q + 7'h1;
                        wptr_q <= wptr_inc;
                        sum_q <= sum_q + SW'(x_q);
                    end
                end
                RNWMF_S_RD: begin
                    wptr_q <= wptr_inc;
                    sum_q <= sum_q - SW'($signed(mem_rdata)) + SW'(x_q);
                end
                RNWMF_S_OUT: begin
                    if (ctrl_q[RNWMF_CTRL_AVG_EN] && !ctrl_q[RNWMF_CTRL_SLIDE]) begin
                        cnt_q <= 7'h0;
                        wptr_q <= '0;
                        sum_q <= '0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // restoring divider for the mean; sign handled on magnitude
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dvd_q <= '0;
            rem_q <= 7'h0;
            div_cnt_q <= 6'h0;
            div_neg_q <= 1'b0;
        end else if (state_q == RNWMF_S_CHK) begin
            dvd_q <= abs_sw(sum_q);
            rem_q <= 7'h0;
            div_cnt_q <= 6'h0;
            div_neg_q <= sum_q[SW-1];
        end else if (state_q == RNWMF_S_DIV) begin
            div_cnt_q <= div_cnt_q + 6'h1;
            if (trial >= {1'b0, depth_q}) begin
                rem_q <= 7'(trial - {1'b0, depth_q});
                dvd_q <= {dvd_q[SW-2:0], 1'b1};
            end else begin
                rem_q <= trial[6:0];
                dvd_q <= {dvd_q[SW-2:0], 1'b0};
            end
        end
    end

    // result and window reference; reference is dropped on restart
    always_ff @(posedge sys_clk) begin
        if (rst || restart_take) begin
            res_q <= '0;
            ref_vld_q <= 1'b0;
            ref_q <= '0;
        end else if (state_q == RNWMF_S_MED) begin
            res_q <= ctrl_q[RNWMF_CTRL_MED_EN] ? med_val : raw_q;
        end else if (state_q == RNWMF_S_DIV && div_cnt_q == 6'(SW - 1)) begin
            res_q <= div_neg_q ? DW'(-quo) : quo;
        end else if (state_q == RNWMF_S_OUT && ctrl_q[RNWMF_CTRL_AVG_EN]) begin
            ref_q <= res_q;
            ref_vld_q <= 1'b1;
        end
    end

    // flushes seen since reset, for software diagnostics
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flush_cnt_q <= 16'h0;
        end else if (state_q == RNWMF_S_NOISE && flush) begin
            flush_cnt_q <= flush_cnt_q + 16'h1;
        end
    end

    // ------------------------------------------------------------
    // output and register read mux
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            out_valid <= (state_q == RNWMF_S_OUT);
            if (state_q == RNWMF_S_OUT) begin
                out_data <= res_q;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else if (avs_read && !ack_q) begin
            rdata_q <= 32'h0; // unmapped reads return zero
            if (set_sel) begin
                unique case (set_idx)
                    2'h0: rdata_q <= {28'h0, ctrl_q};
                    2'h1: rdata_q <= {25'h0, depth_q};
                    2'h2: rdata_q <= {25'h0, tol_q};
                    2'h3: rdata_q <= {29'h0, rank_q};
                endcase
            end else if (avs_address == RNWMF_REG_STATUS) begin
                rdata_q[RNWMF_STAT_FILL_LSB +: 7] <= cnt_q;
                rdata_q[RNWMF_STAT_IDLE] <= (state_q == RNWMF_S_IDLE);
                rdata_q[RNWMF_STAT_REF_VLD] <= ref_vld_q;
                rdata_q[RNWMF_STAT_FLUSH_LSB +: 16] <= flush_cnt_q;
            end else if (avs_address == RNWMF_REG_RESULT) begin
                rdata_q <= 32'(out_data);
            end
        end
    end

endmodule : rnwmf_filter

// file: bench/rnwmf_conv_model.sv
// converter-side model: hands readings to the filter one at a time
// assumes the filter takes a reading on the edge where in_valid and in_ready are high
`timescale 1ns/10ps
module rnwmf_conv_model #(
    parameter int DW = 24
) (
    input wire logic sys_clk,
    input wire logic in_ready,
    output logic in_valid,
    output logic [DW-1:0] in_data
);
    int tmo_count;

    // quiet bus at time zero
    initial begin
        in_valid = 1'b0;
        in_data = '0;
        tmo_count = 0;
    end

    // hold the reading until taken; afterwards the data lines show junk, not the old value
    task automatic send(input logic [DW-1:0] v);
        int n;
        @(posedge sys_clk);
        in_valid <= 1'b1;
        in_data <= v;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (in_ready !== 1'b1 && n < 400);
        if (n >= 400) tmo_count++;
        in_valid <= 1'b0;
        in_data <= ~v;
    endtask : send
endmodule : rnwmf_conv_model

// file: bench/rnwmf_filter_properties.sv
// port checker for the filter stage
// assumes it is bound onto rnwmf_filter, one clock, synchronous reset
`timescale 1ns/10ps
module rnwmf_chk import rnwmf_pkg::*; #(
    parameter int DW = 24
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic [DW-1:0] in_data,
    input wire logic out_valid,
    input wire logic [DW-1:0] out_data
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [3:0] ctrl_q;
    logic [2:0] rank_q;
    logic [DW-1:0] last_q;
    logic take;
    logic rd_ok;
    logic wr_ok;
    logic req;
    assign take = in_valid & in_ready;
    assign rd_ok = avs_read & ~avs_waitrequest;
    assign wr_ok = avs_write & ~avs_waitrequest;
    assign req = avs_read | avs_write;
    // shadow of mode bits, so latency checks know which path is active
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q <= RNWMF_CTRL_RST;
            rank_q <= RNWMF_RANK_RST;
        end else if (wr_ok && !avs_address[3]) begin
            if (avs_address[1:0] == 2'h0) ctrl_q <= avs_writedata[3:0];
            if (avs_address[1:0] == 2'h3) begin
                rank_q <= (avs_writedata > 32'h5) ? 3'h5 : avs_writedata[2:0];
            end
        end
    end
    // last reading taken; in_ready stays low meanwhile so it is stable
    always_ff @(posedge sys_clk) begin
        if (take) last_q <= in_data;
    end
    property p_wait;
        req && !$past(req) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    property p_tol;
        rd_ok && avs_address == RNWMF_REG_NOISE_TOL |-> avs_readdata <= 32'h64;
    endproperty
    property p_rank;
        rd_ok && avs_address == RNWMF_REG_MED_RANK |-> avs_readdata <= 32'h5;
    endproperty
    property p_depth;
        rd_ok && avs_address == RNWMF_REG_AVG_DEPTH |-> avs_readdata inside {[1:100]};
    endproperty
    property p_unmap;
        rd_ok && avs_address > 4'h9 |-> avs_readdata == 32'h0;
    endproperty
    property p_bypass;
        take && ctrl_q[0] == 1'b0 && ctrl_q[3] == 1'b0 |-> ##3 out_valid && out_data == last_q;
    endproperty
    property p_rank0;
        take && ctrl_q == 4'h8 && rank_q == 3'h0 |-> ##[1:8] out_valid && out_data == last_q;
    endproperty
    property p_busy;
        take |=> !in_ready;
    endproperty
    property p_pulse;
        out_valid |=> !out_valid;
    endproperty
    a_wait: assert property (p_wait) else $error("waitrequest not one cycle");
    a_tol: assert property (p_tol) else $error("tolerance above limit");
    a_rank: assert property (p_rank) else $error("rank above limit");
    a_depth: assert property (p_depth) else $error("depth out of range");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_bypass: assert property (p_bypass) else $error("bypass output wrong");
    a_rank0: assert property (p_rank0) else $error("rank zero not forwarded");
    a_busy: assert property (p_busy) else $error("ready while reading in flight");
    a_pulse: assert property (p_pulse) else $error("output valid too long");
    c_avg: cover property (take && ctrl_q[0]);
    c_out: cover property (out_valid);
    c_unmap: cover property (rd_ok && avs_address > 4'h9);
endmodule : rnwmf_chk

bind rnwmf_filter rnwmf_chk #(.DW(DW)) i_rnwmf_chk (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .out_valid(out_valid), .out_data(out_data)
);

// file: bench/tb_rnwmf_filter.sv
// self-checking bench for the filter stage
// assumes a 25 MHz clock and the converter model as the reading source
`timescale 1ns/10ps
module tb_rnwmf_filter import rnwmf_pkg::*; ;
    localparam int DW = 24;
    logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, in_valid, in_ready, out_valid;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [DW-1:0] in_data, out_data;
    logic [DW-1:0] outs_q[$];
    int err_count = 0;
    int comparisons = 0;

    rnwmf_filter #(.DW(DW), .DEPTH(100)) i_rnwmf_filter (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .in_valid(in_valid), .in_ready(in_ready),
        .in_data(in_data), .out_valid(out_valid), .out_data(out_data));
    rnwmf_conv_model #(.DW(DW)) i_src (
        .sys_clk(sys_clk), .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data));

    // ------------------------------------------------------------
    // clock, monitor and shared tasks
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // out_valid stands one cycle, so sample every edge
    always @(posedge sys_clk) begin
        if (out_valid === 1'b1) outs_q.push_back(out_data);
    end
    task automatic conclude();
        if (i_src.tmo_count != 0) err_count++;
        if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic cmp32(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask : cmp32
    // waits for the next filtered reading; a missing one ends the run
    task automatic cmp_out(input logic [DW-1:0] e);
        int n;
        n = 0;
        while (outs_q.size() == 0 && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 300) begin
            err_count++;
            conclude();
        end else begin
            cmp32("out_data", 32'(e), 32'(outs_q.pop_front()));
        end
    endtask : cmp_out
    // one avalon transfer held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        if (n >= 50) begin
            err_count++;
            conclude();
        end else begin
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic chk_rd(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        cmp32("register", e, q);
    endtask : chk_rd
    // checks no stray outputs are left, then programs all settings
    task automatic setup(input logic [3:0] c, input logic [6:0] d, input logic [6:0] t,
                         input logic [2:0] r);
        repeat (60) @(posedge sys_clk);
        cmp32("stray outputs", 32'h0, 32'(outs_q.size()));
        wr(RNWMF_REG_CTRL, 32'(c));
        wr(RNWMF_REG_AVG_DEPTH, 32'(d));
        wr(RNWMF_REG_NOISE_TOL, 32'(t));
        wr(RNWMF_REG_MED_RANK, 32'(r));
    endtask : setup
    task automatic feed(input int v[]);
        foreach (v[i]) i_src.send(DW'(v[i]));
    endtask : feed

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        chk_rd(RNWMF_REG_CTRL, 32'h1);
        chk_rd(RNWMF_REG_AVG_DEPTH, 32'hA);
        chk_rd(RNWMF_REG_NOISE_TOL, 32'h5);
        chk_rd(RNWMF_REG_MED_RANK, 32'h1);
        wr(RNWMF_REG_NOISE_TOL, 32'hC8);
        chk_rd(RNWMF_REG_NOISE_TOL, 32'h64);
        wr(RNWMF_REG_CH2_BASE + RNWMF_REG_NOISE_TOL, 32'h21);
        chk_rd(RNWMF_REG_NOISE_TOL, 32'h21);
        wr(RNWMF_REG_MED_RANK, 32'h7);
        chk_rd(RNWMF_REG_CH2_BASE + RNWMF_REG_MED_RANK, 32'h5);
        wr(RNWMF_REG_AVG_DEPTH, 32'h0);
        chk_rd(RNWMF_REG_AVG_DEPTH, 32'h1);
        wr(RNWMF_REG_AVG_DEPTH, 32'hC8);
        chk_rd(RNWMF_REG_AVG_DEPTH, 32'h64);
        wr(4'hC, 32'h5);
        chk_rd(4'hC, 32'h0);
    endtask : t_regs
    task automatic t_median();
        setup(4'h0, 7'hA, 7'h5, 3'h1);
        feed('{123, -5});
        cmp_out(DW'(123));
        cmp_out(DW'(-5));
        setup(4'h8, 7'hA, 7'h5, 3'h1);
        feed('{5, 1, 9, 2, 8});
        cmp_out(DW'(5));
        cmp_out(DW'(2));
        cmp_out(DW'(8));
        setup(4'h8, 7'hA, 7'h5, 3'h2);
        feed('{3, 1, 4, 1, 5});
        cmp_out(DW'(3));
        setup(4'h8, 7'hA, 7'h5, 3'h0);
        feed('{7, -4});
        cmp_out(DW'(7));
        cmp_out(DW'(-4));
        chk_rd(RNWMF_REG_RESULT, 32'h00FFFFFC);
    endtask : t_median
    task automatic t_average();
        setup(4'h1, 7'h4, 7'h5, 3'h1);
        feed('{10, 20, 30, 40, 1, 1, 1, 1});
        cmp_out(DW'(25));
        cmp_out(DW'(1));
        setup(4'h3, 7'h3, 7'h5, 3'h1);
        feed('{10, 20, 30, 40});
        cmp_out(DW'(20));
        cmp_out(DW'(30));
    endtask : t_average
    // 105 and 95 sit exactly on a 5 percent edge, which is still inside;
    // 200 flushes 101 away, so 200 and 104 pair up (no flush would give 150)
    task automatic t_window();
        setup(4'h5, 7'h2, 7'h5, 3'h1);
        feed('{100, 100, 105, 95, 101, 200, 104});
        cmp_out(DW'(100));
        cmp_out(DW'(100));
        cmp_out(DW'(152));
        chk_rd(RNWMF_REG_STATUS, 32'h00010300);
        setup(4'h1, 7'h2, 7'h5, 3'h1);
        feed('{100, 100, 101, 200});
        cmp_out(DW'(100));
        cmp_out(DW'(150));
    endtask : t_window

    // reset for two cycles, then the scenarios in turn
    initial begin
        rst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_median();
        t_average();
        t_window();
        setup(4'h1, 7'hA, 7'h5, 3'h1);
        conclude();
    end
endmodule : tb_rnwmf_filter
